// ---- verilog/aprs_defs.svh ----
// constants for the converter parallel readout block
// assumes inclusion by files under verilog/ only
`ifndef APRS_DEFS_SVH
`define APRS_DEFS_SVH

// pin bundle positions in the input synchroniser
`define APRS_PIN_N       7
`define APRS_PIN_RD      0
`define APRS_PIN_CS      1
`define APRS_PIN_SYNC    2
`define APRS_PIN_RANGE   3
`define APRS_PIN_PD      4
`define APRS_PIN_MODE_A  5
`define APRS_PIN_MODE_B  6
`define APRS_PIN_RST     7'h03

// mode pin levels that select parallel readout
`define APRS_PAR_MODE_A  1'b0
`define APRS_PAR_MODE_B  1'b0

// data ready high cycles ahead of an unread update
`define APRS_PRE_CYCLES  2
`define APRS_DATA_READY_N_IDLE   1'b1
`define APRS_OE_OFF      1'b1

`endif

// ---- verilog/aprs_pkg.sv ----
// types for the converter parallel readout block
// assumes aprs_defs.svh is on the include path
package aprs_pkg;
    typedef enum logic [1:0] {
        APRS_FLT_RUN     = 2'b00,
        APRS_FLT_RESET   = 2'b01,
        APRS_FLT_SETTLE  = 2'b10,
        APRS_FLT_STANDBY = 2'b11
    } aprs_flt_t;
endpackage

// ---- verilog/aprs_readout.sv ----
// converter word fifo and parallel readout top
// assumes one master clock, synchronous reset, pins asynchronous to clk
`timescale 1ns/1ns
`default_nettype none
`include "aprs_defs.svh"

module aprs_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 4
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         flush,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem_q [DEPTH];
    logic [W-1:0]  mem_d [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] wp_d;
    logic [AW-1:0] rp_q;
    logic [AW-1:0] rp_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_q != CW'(DEPTH)) && !flush;
    assign out_valid = (cnt_q != '0) && !flush;
    assign out_data  = mem_q[rp_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        mem_d = mem_q;
        wp_d  = wp_q;
        rp_d  = rp_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wp_q] = in_data;
            wp_d        = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
        end
        if (pop) begin
            rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
        if (flush) begin
            wp_d  = '0;
            rp_d  = '0;
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        mem_q <= mem_d;
        if (reset) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end
endmodule

module aprs_readout
    import aprs_pkg::*;
#(
    parameter int WORD_W       = 16,
    parameter int DECIM        = 8,
    parameter int SETTLE_WORDS = 2,
    parameter int FIFO_DEPTH   = 4
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic [WORD_W-1:0] sample_data,
    input  wire logic              sample_valid,
    output logic                   sample_ready,
    input  wire logic              rd_n,
    input  wire logic              cs_n,
    input  wire logic              sync,
    input  wire logic              input_range_select,
    input  wire logic              power_down_request,
    input  wire logic              interface_mode_pin_a,
    input  wire logic              interface_mode_pin_b,
    output logic [WORD_W-1:0]      out_bus,
    output logic                   out_bus_oe_n,
    output logic                   data_ready_n,
    output logic                   range_unipolar,
    output logic                   powered_down,
    output logic                   parallel_mode
);
    localparam int CNT_W = $clog2(DECIM);
    localparam int SET_W = $clog2(SETTLE_WORDS + 1);

    // pin synchronisers
    logic [`APRS_PIN_N-1:0] pin_s1_q;
    logic [`APRS_PIN_N-1:0] pin_s2_q;
    logic                   sync_s3_q;
    logic                   rd_s;
    logic                   cs_s;
    logic                   sync_s;
    logic                   sync_rise;
    logic                   par_s;

    // sequencer, output word and handshake state
    aprs_flt_t         flt_q;
    aprs_flt_t         flt_d;
    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  cnt_d;
    logic [SET_W-1:0]  settle_q;
    logic [SET_W-1:0]  settle_d;
    logic [WORD_W-1:0] word_q;
    logic [WORD_W-1:0] word_d;
    logic              pending_q;
    logic              pending_d;
    logic              data_ready_n_n_q;
    logic              data_ready_n_n_d;
    logic              oe_n_q;
    logic              oe_n_d;
    logic              rd_act_q;
    logic              rd_act_d;
    logic              range_q;
    logic              pd_q;
    logic              par_q;
    logic              rd_done;
    logic              update;
    logic              update_load;
    logic              hold;
    logic [WORD_W-1:0] fifo_data;
    logic              fifo_valid;

    assign rd_s      = pin_s2_q[`APRS_PIN_RD];
    assign cs_s      = pin_s2_q[`APRS_PIN_CS];
    assign sync_s    = pin_s2_q[`APRS_PIN_SYNC];
    assign sync_rise = sync_s && !sync_s3_q;
    assign par_s     = (pin_s2_q[`APRS_PIN_MODE_A] == `APRS_PAR_MODE_A)
                    && (pin_s2_q[`APRS_PIN_MODE_B] == `APRS_PAR_MODE_B);

    assign hold        = (flt_q == APRS_FLT_RESET) || (flt_q == APRS_FLT_STANDBY);
    assign update      = !hold && (cnt_q == CNT_W'(DECIM - 1)) && fifo_valid;
    assign update_load = update && (flt_q == APRS_FLT_RUN);
    assign rd_done     = rd_act_q && (rd_s || cs_s);

    aprs_fifo #(
        .W     (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .flush     (hold),
        .in_data   (sample_data),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (update)
    );

    always_comb begin
        flt_d    = flt_q;
        cnt_d    = cnt_q;
        settle_d = settle_q;
        unique case (flt_q)
            APRS_FLT_RUN, APRS_FLT_SETTLE: begin
                cnt_d = (cnt_q == CNT_W'(DECIM - 1)) ? '0 : cnt_q + 1'b1;
                if (update && (flt_q == APRS_FLT_SETTLE)) begin
                    settle_d = settle_q - 1'b1;
                    if (settle_q == SET_W'(1)) begin
                        flt_d = APRS_FLT_RUN;
                    end
                end
            end
            APRS_FLT_RESET: begin
                if (!sync_s) begin
                    flt_d = APRS_FLT_SETTLE;
                end
            end
            APRS_FLT_STANDBY: begin
                flt_d    = APRS_FLT_SETTLE;
                settle_d = SET_W'(SETTLE_WORDS);
            end
        endcase
        if (pin_s2_q[`APRS_PIN_PD]) begin
            flt_d = APRS_FLT_STANDBY;
            cnt_d = '0;
        end else if (sync_rise) begin
            flt_d    = APRS_FLT_RESET;
            cnt_d    = '0;
            settle_d = SET_W'(SETTLE_WORDS);
        end
        if (flt_d == APRS_FLT_SETTLE && settle_d == '0) begin
            flt_d = APRS_FLT_RUN;
        end
    end

    always_comb begin
        word_d    = update_load ? fifo_data : word_q;
        rd_act_d  = !rd_s && !cs_s;
        oe_n_d    = !(!rd_s && !cs_s && par_s);
        pending_d = pending_q;
        if (rd_done) begin
            pending_d = 1'b0;
        end
        if (hold || flt_d != flt_q && flt_d != APRS_FLT_RUN) begin
            pending_d = 1'b0;
        end
        if (update_load) begin
            pending_d = 1'b1;
        end
        data_ready_n_n_d = !pending_d || (cnt_d >= CNT_W'(DECIM - `APRS_PRE_CYCLES));
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pin_s1_q  <= `APRS_PIN_RST;
            pin_s2_q  <= `APRS_PIN_RST;
            sync_s3_q <= 1'b0;
            flt_q     <= APRS_FLT_RESET;
            cnt_q     <= '0;
            settle_q  <= SET_W'(SETTLE_WORDS);
            word_q    <= '0;
            pending_q <= 1'b0;
            data_ready_n_n_q  <= `APRS_DATA_READY_N_IDLE;
            oe_n_q    <= `APRS_OE_OFF;
            rd_act_q  <= 1'b0;
            range_q   <= 1'b0;
            pd_q      <= 1'b0;
            par_q     <= 1'b0;
        end else begin
            pin_s1_q  <= {interface_mode_pin_b, interface_mode_pin_a, power_down_request,
                          input_range_select, sync, cs_n, rd_n};
            pin_s2_q  <= pin_s1_q;
            sync_s3_q <= sync_s;
            flt_q     <= flt_d;
            cnt_q     <= cnt_d;
            settle_q  <= settle_d;
            word_q    <= word_d;
            pending_q <= pending_d;
            data_ready_n_n_q  <= data_ready_n_n_d;
            oe_n_q    <= oe_n_d;
            rd_act_q  <= rd_act_d;
            range_q   <= pin_s2_q[`APRS_PIN_RANGE];
            pd_q      <= pin_s2_q[`APRS_PIN_PD];
            par_q     <= par_s;
        end
    end

    assign out_bus        = word_q;
    assign out_bus_oe_n   = oe_n_q;
    assign data_ready_n   = data_ready_n_n_q;
    assign range_unipolar = range_q;
    assign powered_down   = pd_q;
    assign parallel_mode  = par_q;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_two_high;
        data_ready_n [*2];
    endsequence

    sequence s_word_fresh;
        !data_ready_n && pending_q;
    endsequence

    chk_bus_enable: assert property (!rd_s && !cs_s && par_s |=> !out_bus_oe_n)
        else $error("bus not enabled after strobe and select low");
    chk_bus_release: assert property (rd_s |=> out_bus_oe_n)
        else $error("bus driven while read strobe high");
    chk_filter_clear: assert property (sync_rise && !pin_s2_q[`APRS_PIN_PD]
        |=> cnt_q == '0 && flt_q == APRS_FLT_RESET)
        else $error("restart edge did not clear sequencer");
    chk_filter_release: assert property (flt_q == APRS_FLT_RESET && !sync_s
        && !pin_s2_q[`APRS_PIN_PD] |=> flt_q != APRS_FLT_RESET)
        else $error("filter reset not released");
    chk_ready_fall: assert property (update_load |=> s_word_fresh)
        else $error("data ready did not fall on fresh word");
    chk_ready_rise: assert property (rd_done && !update_load |=> data_ready_n)
        else $error("data ready stayed low after read");
    chk_ready_pulse: assert property (!hold && cnt_q == CNT_W'(DECIM - 3)
        && flt_d == flt_q |=> s_two_high)
        else $error("data ready not high before update");
    chk_settle_quiet: assert property (flt_q != APRS_FLT_RUN |-> ##1 data_ready_n)
        else $error("data ready active before valid results");
    chk_range_flag: assert property (pin_s2_q[`APRS_PIN_RANGE] |=> range_unipolar)
        else $error("unipolar range not flagged");
    chk_power_hold: assert property (pin_s2_q[`APRS_PIN_PD]
        |=> powered_down && flt_q == APRS_FLT_STANDBY && cnt_q == '0)
        else $error("standby not entered");
endmodule

`default_nettype wire

// ---- tb/aprs_host_model.sv ----
// host model reading converter words over the parallel bus
// assumes design drives bus and enable; bench calls the tasks
`timescale 1ns/1ns
`default_nettype none
module aprs_host_model (
    input  wire logic        clk,
    input  wire logic [15:0] out_bus,
    input  wire logic        out_bus_oe_n,
    output var logic         rd_n,
    output var logic         cs_n,
    output var logic         mode_a,
    output var logic         mode_b
);
    logic [15:0] last_q = 16'h0000;
    logic [15:0] bus_w;
    // released bus shows inverse of last driven word
    assign bus_w = out_bus_oe_n ? ~last_q : out_bus;
    always @(posedge clk) if (!out_bus_oe_n) last_q <= out_bus;
    initial begin
        rd_n = 1'b1;
        cs_n = 1'b1;
        mode_a = 1'b0;
        mode_b = 1'b0;
    end
    task automatic set_mode(input logic a, input logic b);
        @(negedge clk);
        mode_a = a;
        mode_b = b;
    endtask
    // strobe held until drive is seen or 8 cycles pass, then for hold more cycles, then released
    task automatic read_word(input logic sel, input int hold,
                             output logic [15:0] w, output logic seen);
        int n;
        @(negedge clk);
        rd_n = 1'b0;
        cs_n = !sel;
        seen = 1'b0;
        w = 16'h0000;
        for (n = 0; n < 8 && !seen; n++) begin
            @(posedge clk);
            seen = (out_bus_oe_n === 1'b0);
            w = bus_w;
        end
        repeat (hold) @(posedge clk);
        @(negedge clk);
        rd_n = 1'b1;
        cs_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// ---- tb/tb_aprs_readout.sv ----
// bench for the converter parallel readout block
// assumes design and host model compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_aprs_readout;
    localparam int DEC    = 16;
    localparam int SETTLE = 2;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [15:0] sample_data = 16'h0000;
    logic        sample_valid = 1'b0;
    logic        sample_ready, rd_n, cs_n, mode_a, mode_b;
    logic        sync = 1'b0;
    logic        input_range_select = 1'b0;
    logic        power_down_request = 1'b0;
    logic [15:0] out_bus;
    logic        out_bus_oe_n, data_ready_n, range_unipolar, powered_down, parallel_mode;
    logic [15:0] w;
    logic        seen;
    logic        saw_full = 1'b0;
    int          err_count = 0;
    int          n_tests = 0;
    int          sent_n = 0;
    int          feed_lim = 0;
    int          n, k;

    aprs_readout #(.DECIM(DEC), .SETTLE_WORDS(SETTLE)) dut_u (
        .clk(clk), .reset(reset), .sample_data(sample_data),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .rd_n(rd_n),
        .cs_n(cs_n), .sync(sync), .input_range_select(input_range_select),
        .power_down_request(power_down_request), .interface_mode_pin_a(mode_a),
        .interface_mode_pin_b(mode_b), .out_bus(out_bus), .out_bus_oe_n(out_bus_oe_n),
        .data_ready_n(data_ready_n), .range_unipolar(range_unipolar),
        .powered_down(powered_down), .parallel_mode(parallel_mode));
    aprs_host_model host_u (
        .clk(clk), .out_bus(out_bus), .out_bus_oe_n(out_bus_oe_n), .rd_n(rd_n),
        .cs_n(cs_n), .mode_a(mode_a), .mode_b(mode_b));

    always #25 clk = ~clk;
    function automatic logic [15:0] word_of(input int i);
        return 16'h8a50 + i[15:0];
    endfunction
    // filter side offers words up to feed_lim
    always @(negedge clk) begin
        sample_valid = (sent_n < feed_lim);
        sample_data = word_of(sent_n);
    end
    always @(posedge clk) begin
        if (sample_valid && sample_ready) sent_n <= sent_n + 1;
        if (sample_valid && !sample_ready) saw_full <= 1'b1;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string s);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
        end
    endtask
    task automatic check_cnt(input int got, input int lo, input int hi, input string s);
        n_tests++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("wrong value at %0t: %s count %0d", $time, s, got);
        end
    endtask
    task automatic wait_level(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (data_ready_n !== lvl && cnt < lim) begin
            @(posedge clk);
            cnt++;
        end
    endtask
    task automatic read_check(input int idx, input int hold);
        host_u.read_word(1'b1, hold, w, seen);
        check({15'h0000, seen}, 16'h0001, "drive");
        check(w, word_of(idx), "word");
        repeat (4) @(negedge clk);
        check({15'h0000, out_bus_oe_n}, 16'h0001, "release");
        check({15'h0000, data_ready_n}, 16'h0001, "flag clear");
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        end_of_test;
    end

    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        check(out_bus, 16'h0000, "reset bus");
        check({14'h0000, out_bus_oe_n, data_ready_n}, 16'h0003, "reset flags");
        for (n = 0; n < 2; n++) begin
            input_range_select = n[0];
            repeat (4) @(negedge clk);
            check({15'h0000, range_unipolar}, {15'h0000, n[0]}, "range");
        end
        host_u.set_mode(1'b1, 1'b0);
        repeat (4) @(negedge clk);
        check({15'h0000, parallel_mode}, 16'h0000, "mode");
        host_u.read_word(1'b1, 0, w, seen);
        check({15'h0000, seen}, 16'h0000, "drive off mode");
        host_u.set_mode(1'b0, 1'b0);
        repeat (4) @(negedge clk);
        check({15'h0000, parallel_mode}, 16'h0001, "mode");
        host_u.read_word(1'b0, 0, w, seen);
        check({15'h0000, seen}, 16'h0000, "drive no select");
        $display("test pins done");
        feed_lim = SETTLE + 1;
        wait_level(1'b0, 300, k);
        check_cnt(k, 1, 299, "first word");
        read_check(SETTLE, 0);
        repeat (2 * DEC) @(negedge clk);
        check({15'h0000, data_ready_n}, 16'h0001, "no fresh word");
        $display("test single done");
        saw_full = 1'b0;
        feed_lim = SETTLE + 11;
        for (n = 1; n < 11; n++) begin
            wait_level(1'b0, 40, k);
            check_cnt(k, 0, 39, "update");
            read_check(n + SETTLE, n % 3);
        end
        check({15'h0000, saw_full}, 16'h0001, "fifo refusal");
        feed_lim = SETTLE + 13;
        wait_level(1'b0, 40, k);
        wait_level(1'b1, 40, k);
        wait_level(1'b0, 10, k);
        check_cnt(k, 2, 2, "unread pulse");
        read_check(SETTLE + 12, 0);
        $display("test fifo done");
        feed_lim = 40;
        wait_level(1'b0, 40, k);
        @(negedge clk);
        sync = 1'b1;
        repeat (20) @(negedge clk);
        check({15'h0000, data_ready_n}, 16'h0001, "held");
        sync = 1'b0; // single pulse, long gap
        n = sent_n;
        wait_level(1'b0, 200, k);
        check_cnt(k, SETTLE * DEC, (SETTLE + 1) * DEC + 12, "settle");
        read_check(n + SETTLE, 0);
        $display("test restart done");
        wait_level(1'b0, 40, k);
        @(negedge clk);
        power_down_request = 1'b1;
        repeat (5) @(negedge clk);
        check({13'h0000, powered_down, sample_ready, data_ready_n}, 16'h0005, "standby");
        power_down_request = 1'b0;
        repeat (5) @(negedge clk);
        check({15'h0000, powered_down}, 16'h0000, "awake");
        $display("test standby done");
        end_of_test;
    end
endmodule
`default_nettype wire
